/* File: common/alarm_encoder_defines.vh */
`ifndef ALARM_ENCODER_DEFINES_VH
`define ALARM_ENCODER_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define REG_COND     4'h0
`define REG_CTRL     4'h1
`define REG_STATUS   4'h2
`define REG_IRQ      4'h3
`define REG_MASK     4'h4

// ****************************************
// Condition bit positions
// ****************************************
`define C_THERM_ALARM 0
`define C_THERM_SHUT  1
`define C_FAN_FAIL    2
`define C_FUSE_BLOWN  3
`define C_IN_LIMITS   4
`define C_IN_ABSENT   5
`define C_BOOST_FAIL  6
`define C_OV_LATCH    7
`define C_OVER_CURR   8
`define C_INT_FAULT   9
`define C_SERVICE     10
`define C_COMM_FAIL   11
`define C_BOOST_DECAY 12
`define C_HIGH_RATING 13
`define C_ALERT0      14
`define C_ALERT1      15

// ****************************************
// Reset values and timing
// ****************************************
`define COND_RESET    16'h0000
`define CTRL_RESET    2'h0
`define MASK_RESET    8'h00
`define BLINK_HALF_NS 250000000
`define CLK_PERIOD_NS 4
`define BLINK_HALF_CYC (`BLINK_HALF_NS / `CLK_PERIOD_NS)
`define PFW_LEAD_MS   5

`endif

/* File: src/rectifier_alarm_led_encoder.v */
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "alarm_encoder_defines.vh"

module rectifier_alarm_led_encoder #(
  parameter integer BLINK_HALF = `BLINK_HALF_CYC
)(
  // Clock and reset
  input  wire        sys_clk_in,
  input  wire        rst_n_in,
  // Register port
  input  wire [3:0]  addr_in,
  input  wire [15:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [15:0] rdata_out,
  // Control pins from the controller side
  input  wire        enable_n_in,
  input  wire        hotplug_n_in,
  input  wire        protocol_open_in,
  // Lamps
  output reg         input_ok_lamp_out,
  output reg         output_ok_lamp_out,
  output reg         service_lamp_out,
  output reg         fault_lamp_out,
  // Open-drain alarm lines: oe low means pulling the line low
  output reg         fault_oe_n_out,
  output reg         over_temp_warning_oe_n_out,
  output reg         power_fail_warning_oe_n_out,
  output reg         power_cap_oe_n_out,
  output reg         module_present_flag_oe_n_out,
  output reg         alert0_oe_n_out,
  output reg         alert1_oe_n_out,
  // Main output control and status
  output reg         main_output_on_out,
  output reg         rs485_mode_out,
  output reg         irq_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [2:0] en_sync;
  reg [2:0] hp_sync;
  reg [2:0] pr_sync;
  reg       en_n;
  reg       hp_n;
  reg       pr_open;

  // Three stages; a change counts once stages two and three agree
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      en_sync <= 3'h7;
      hp_sync <= 3'h7;
      pr_sync <= 3'h7;
      en_n    <= 1'b1;
      hp_n    <= 1'b1;
      pr_open <= 1'b1;
    end
    else
    begin
      en_sync <= {en_sync[1:0], enable_n_in};
      hp_sync <= {hp_sync[1:0], hotplug_n_in};
      pr_sync <= {pr_sync[1:0], protocol_open_in};
      if (en_sync[1] == en_sync[2])
        en_n <= en_sync[2];
      if (hp_sync[1] == hp_sync[2])
        hp_n <= hp_sync[2];
      if (pr_sync[1] == pr_sync[2])
        pr_open <= pr_sync[2];
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  reg [15:0] cond;
  reg [1:0]  ctrl;
  reg [7:0]  irq_stat;
  reg [7:0]  irq_mask;
  reg [7:0]  ev_prev;
  reg        blink;                              // Blink phase, driven below
  wire [7:0] ev_now;
  wire [7:0] ev_rise;
  wire       rs485;

  assign rs485 = ~pr_open;

  // Events: thermal alarm and shutdown, fan, boost, OV latch (not fuse blown), internal fault, comm fail, output drop
  assign ev_now = {~main_output_on_out, cond[`C_COMM_FAIL], cond[`C_INT_FAULT],
                   cond[`C_OV_LATCH], cond[`C_BOOST_FAIL], cond[`C_FAN_FAIL],
                   cond[`C_THERM_SHUT], cond[`C_THERM_ALARM]};
  assign ev_rise = ev_now & ~ev_prev;

  // Writes, sticky status with set winning over clear
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cond     <= `COND_RESET;
      ctrl     <= `CTRL_RESET;
      irq_stat <= 8'h00;
      irq_mask <= `MASK_RESET;
      ev_prev  <= 8'h80;                         // Output starts off: no false event
    end
    else
    begin
      ev_prev <= ev_now;
      if (wr_in && addr_in == `REG_COND)
        cond <= wdata_in;
      if (wr_in && addr_in == `REG_CTRL)
        ctrl <= wdata_in[1:0];
      if (wr_in && addr_in == `REG_MASK)
        irq_mask <= wdata_in[7:0];
      if (wr_in && addr_in == `REG_IRQ)
        irq_stat <= (irq_stat & ~wdata_in[7:0]) | ev_rise;
      else
        irq_stat <= irq_stat | ev_rise;
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= 16'h0000;
    else if (rd_in)
    begin
      case (addr_in)
        `REG_COND:   rdata_out <= cond;
        `REG_CTRL:   rdata_out <= {14'h0000, ctrl};
        `REG_STATUS: rdata_out <= {11'h000, rs485, ~hp_n, ~en_n,
                                   main_output_on_out, blink};
        `REG_IRQ:    rdata_out <= {8'h00, irq_stat};
        `REG_MASK:   rdata_out <= {8'h00, irq_mask};
        default:     rdata_out <= 16'h0000;
      endcase
    end
    else
      rdata_out <= 16'h0000;
  end

  // ****************************************
  // Blink generator
  // ****************************************
  reg [31:0] blink_cnt;

  // Toggle every half period for an even duty cycle
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      blink_cnt <= 32'h00000000;
      blink     <= 1'b0;
    end
    else if (blink_cnt >= BLINK_HALF - 1)
    begin
      blink_cnt <= 32'h00000000;
      blink     <= ~blink;
    end
    else
      blink_cnt <= blink_cnt + 32'h00000001;
  end

  // ****************************************
  // Condition encoder
  // ****************************************
  reg  next_in_ok;
  reg  next_out_ok;
  reg  next_service;
  reg  next_fault_lamp;
  reg  next_fault;
  reg  next_otw;
  reg  next_pfw;
  reg  next_on;
  wire shutdown;
  wire standby;

  // Shutdown class dominates everything below it
  assign shutdown = cond[`C_THERM_SHUT] | cond[`C_FAN_FAIL] | cond[`C_FUSE_BLOWN] |
                    cond[`C_BOOST_FAIL] | cond[`C_OV_LATCH];
  // Standby via host control bit, enable pin outside RS-485 mode, or hot-plug pin
  assign standby  = ctrl[0] | hp_n | (~rs485 & en_n);

  // Lamps and alarm levels (1 = line high) by severity
  always @*
  begin
    next_in_ok      = 1'b1;
    next_out_ok     = 1'b1;
    next_service    = 1'b0;
    next_fault_lamp = 1'b0;
    next_fault      = 1'b1;
    next_otw        = 1'b1;
    next_pfw        = ~cond[`C_BOOST_DECAY];
    next_on         = ~hp_n & (rs485 | ~en_n) & ~ctrl[0];
    if (cond[`C_SERVICE] && !rs485)
      next_service = blink;
    if (cond[`C_COMM_FAIL] && rs485)
      next_fault_lamp = blink;
    if (cond[`C_INT_FAULT])
    begin
      next_fault_lamp = 1'b1;
      next_fault      = 1'b0;
    end
    if (cond[`C_OVER_CURR])
    begin
      next_out_ok = blink;
      next_pfw    = 1'b0;
    end
    if (standby)
    begin
      next_out_ok = 1'b0;
      next_pfw    = 1'b0;
    end
    if (cond[`C_THERM_ALARM])
    begin
      next_service = 1'b1;
      next_otw     = 1'b0;
    end
    if (shutdown)
    begin
      next_out_ok     = 1'b0;
      next_fault_lamp = 1'b1;
      next_fault      = 1'b0;
      next_pfw        = 1'b0;
      next_on         = 1'b0;
    end
    if (cond[`C_THERM_SHUT])
    begin
      next_service = 1'b1;
      next_otw     = 1'b0;
    end
    if (cond[`C_IN_LIMITS] && !shutdown)
    begin
      next_in_ok  = blink;
      next_out_ok = 1'b0;
      next_service = 1'b0;
      next_fault_lamp = 1'b0;
    end
    if (cond[`C_IN_ABSENT])
    begin
      next_in_ok      = 1'b0;
      next_out_ok     = 1'b0;
      next_service    = 1'b0;
      next_fault_lamp = 1'b0;
      next_pfw        = 1'b0;
      next_on         = 1'b0;
    end
  end

  // Registered outputs; open-drain enables are active low
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      input_ok_lamp_out            <= 1'b0;
      output_ok_lamp_out           <= 1'b0;
      service_lamp_out             <= 1'b0;
      fault_lamp_out               <= 1'b0;
      fault_oe_n_out               <= 1'b1;
      over_temp_warning_oe_n_out   <= 1'b1;
      power_fail_warning_oe_n_out  <= 1'b1;
      power_cap_oe_n_out           <= 1'b1;
      module_present_flag_oe_n_out <= 1'b0;
      alert0_oe_n_out              <= 1'b1;
      alert1_oe_n_out              <= 1'b1;
      main_output_on_out           <= 1'b0;
      rs485_mode_out               <= 1'b0;
      irq_out                      <= 1'b0;
    end
    else
    begin
      input_ok_lamp_out            <= next_in_ok;
      output_ok_lamp_out           <= next_out_ok;
      service_lamp_out             <= next_service;
      fault_lamp_out               <= next_fault_lamp;
      fault_oe_n_out               <= next_fault;
      over_temp_warning_oe_n_out   <= next_otw;
      power_fail_warning_oe_n_out  <= next_pfw;
      power_cap_oe_n_out           <= cond[`C_HIGH_RATING];
      module_present_flag_oe_n_out <= 1'b0;
      alert0_oe_n_out              <= ~(cond[`C_ALERT0] & ~rs485);
      alert1_oe_n_out              <= ~(cond[`C_ALERT1] & ~rs485);
      main_output_on_out           <= next_on;
      rs485_mode_out               <= rs485;
      irq_out                      <= |(irq_stat & irq_mask);
    end
  end

endmodule

/* File: tb/shelf_controller.sv */
`timescale 1ns/1ns
// ****************************************
// Shelf controller side of the alarm pins
// ****************************************
module shelf_controller (
  // From the rectifier
  input  wire [6:0] oe_n_in,
  // From the test sequence
  input  wire       rs485_req_in,
  // Resolved pins
  output wire [6:0] line_out,
  output wire       protocol_open_out
);
  // Pull-ups read a released line as high
  assign line_out = oe_n_in;
  // Resistor fitted selects the second protocol
  assign protocol_open_out = ~rs485_req_in;
endmodule

/* File: tb/alarm_monitor.sv */
`timescale 1ns/1ns
// ****************************************
// Alarm encoder checks
// ****************************************
module alarm_monitor (
  // Clock and reset
  input wire sys_clk_in,
  input wire rst_n_in,
  // Pins
  input wire enable_n_in,
  input wire hotplug_n_in,
  input wire protocol_open_in,
  // Outputs
  input wire input_ok_lamp_out,
  input wire service_lamp_out,
  input wire fault_lamp_out,
  input wire fault_oe_n_out,
  input wire over_temp_warning_oe_n_out,
  input wire module_present_flag_oe_n_out,
  input wire alert0_oe_n_out,
  input wire alert1_oe_n_out,
  input wire main_output_on_out,
  input wire rs485_mode_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Relations between lamps and lines
  a_present_low: assert property (!module_present_flag_oe_n_out)
    else $error("present line released");
  a_fault_lamp: assert property (!fault_oe_n_out |-> fault_lamp_out)
    else $error("fault line without lamp");
  a_fault_input: assert property (!fault_oe_n_out |-> input_ok_lamp_out)
    else $error("fault line without input lamp");
  a_otw_service: assert property (!over_temp_warning_oe_n_out |-> service_lamp_out)
    else $error("warning without service lamp");
  a_otw_input: assert property (!over_temp_warning_oe_n_out |-> input_ok_lamp_out)
    else $error("warning without input lamp");
  // Output gating by the pins
  a_enable_off: assert property ((enable_n_in && protocol_open_in) [*8] |->
    !main_output_on_out)
    else $error("output on while enable open");
  a_hotplug_off: assert property (hotplug_n_in [*8] |-> !main_output_on_out)
    else $error("output on while unmated");
  a_alert_quiet: assert property (rs485_mode_out && $past(rs485_mode_out) |->
    alert0_oe_n_out && alert1_oe_n_out)
    else $error("alert in serial mode");
  c_fault: cover property (!fault_oe_n_out);
  c_otw: cover property (!over_temp_warning_oe_n_out);
  c_main_on: cover property ($rose(main_output_on_out));
endmodule

bind rectifier_alarm_led_encoder alarm_monitor mon (.*);

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`include "alarm_encoder_defines.vh"
module testbench;
  localparam integer HB = 4;
  logic sys_clk_in, rst_n_in, wr_in, rd_in, enable_n_in, hotplug_n_in, rs485_req;
  logic [3:0] addr_in;
  logic [15:0] wdata_in, d, n;
  logic [23:0] rows [11];
  wire [15:0] rdata_out;
  wire protocol_open_in, input_ok_lamp_out, output_ok_lamp_out;
  wire service_lamp_out, fault_lamp_out, fault_oe_n_out, over_temp_warning_oe_n_out;
  wire power_fail_warning_oe_n_out, power_cap_oe_n_out, module_present_flag_oe_n_out;
  wire alert0_oe_n_out, alert1_oe_n_out, main_output_on_out, rs485_mode_out, irq_out;
  wire [6:0] line;
  int num_errors, tests_run;
  rectifier_alarm_led_encoder #(.BLINK_HALF(HB)) dut (.*);
  shelf_controller ctl (
    .oe_n_in({fault_oe_n_out, over_temp_warning_oe_n_out, power_fail_warning_oe_n_out,
      power_cap_oe_n_out, module_present_flag_oe_n_out, alert0_oe_n_out, alert1_oe_n_out}),
    .rs485_req_in(rs485_req),
    .line_out(line),
    .protocol_open_out(protocol_open_in)
  );
  // ****************************************
  // Bus cycles and checks
  // ****************************************
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task w(input int c);
    repeat (c) @(posedge sys_clk_in);
    #1;
  endtask
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  // Counts lit cycles of a lamp over two blink periods
  task cnt(input int k);
    n = 0;
    repeat (4 * HB)
    begin
      w(1);
      n = n + (k ? fault_lamp_out : input_ok_lamp_out);
    end
  endtask
  task conclude;
    if (num_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Clock
  initial
  begin
    sys_clk_in = 0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  // Watchdog
  initial
  begin
    #20000;
    num_errors++;
    conclude();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rst_n_in, wr_in, rd_in, enable_n_in, hotplug_n_in, rs485_req} = 0;
    addr_in = 0;
    wdata_in = 0;
    rows = '{24'h0000ce, 24'h0001ea, 24'h0002b0, 24'h000494, 24'h000894, 24'h004094,
      24'h0200d6, 24'h00200c, 24'h1000cc, 24'h0005b0, 24'h008094};
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    w(8);
    rd(4'hf);
    chk("unmapped", 16'h0000, d);
    // Condition table: lamps and lines
    foreach (rows[i])
    begin
      wr(`REG_COND, rows[i][23:8]);
      w(3);
      chk("state", {8'h00, rows[i][7:0]}, {input_ok_lamp_out, output_ok_lamp_out,
        service_lamp_out, fault_lamp_out, line[6:4], line[2]});
    end
    wr(`REG_COND, 16'h0010);
    cnt(0);
    chk("in_blink", 2 * HB, n);
    chk("in_lines", 2'h3, line[6:5]);
    @(posedge sys_clk_in) rs485_req <= 1'b1;
    wr(`REG_COND, 16'hc800);
    w(8);
    cnt(1);
    chk("comm_blink", 2 * HB, n);
    chk("comm_lines", 5'h1f, {line[6:4], line[1:0]});
    chk("rs485", 1'b1, rs485_mode_out);
    @(posedge sys_clk_in) rs485_req <= 1'b0;
    wr(`REG_COND, 16'h4000);
    w(8);
    chk("alert", 16'h0001, line[1:0]);
    wr(`REG_COND, 16'h2000);
    w(3);
    chk("cap_hi", 1'b1, line[3]);
    wr(`REG_COND, 16'h0000);
    w(3);
    chk("cap_lo", 1'b0, line[3]);
    chk("main_on", 1'b1, main_output_on_out);
    @(posedge sys_clk_in) enable_n_in <= 1'b1;
    w(10);
    chk("enable_off", 1'b0, main_output_on_out);
    @(posedge sys_clk_in) enable_n_in <= 1'b0;
    hotplug_n_in <= 1'b1;
    w(10);
    chk("unmated_off", 1'b0, main_output_on_out);
    @(posedge sys_clk_in) hotplug_n_in <= 1'b0;
    // Remote standby through the control register
    wr(`REG_CTRL, 16'h0001);
    w(8);
    chk("standby", 16'h008c, {input_ok_lamp_out, output_ok_lamp_out, service_lamp_out,
      fault_lamp_out, line[6:4], line[2]});
    chk("standby_off", 1'b0, main_output_on_out);
    rd(`REG_STATUS);
    chk("status", 4'h6, d[4:1]);
    rd(`REG_CTRL);
    chk("ctrl", 16'h0001, d);
    wr(`REG_CTRL, 16'h0000);
    // Interrupt raise, mask and clear
    wr(`REG_IRQ, 16'h00ff);
    wr(`REG_MASK, 16'h0001);
    w(2);
    chk("irq_idle", 1'b0, irq_out);
    wr(`REG_COND, 16'h0001);
    w(3);
    chk("irq_on", 1'b1, irq_out);
    wr(`REG_MASK, 16'h0000);
    w(2);
    chk("irq_masked", 1'b0, irq_out);
    rd(`REG_IRQ);
    chk("irq_stat", 1'b1, d[0]);
    wr(`REG_IRQ, 16'h00ff);
    rd(`REG_IRQ);
    chk("irq_clr", 1'b0, d[0]);
    conclude();
  end
endmodule
